// File: dv/gate_pulse_src.sv
// gate source model: one high pulse of a requested width
// assumes fire is a one-cycle request in the clk domain
`timescale 1ns/1ps
`default_nettype none
module gate_pulse_src (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       fire,
	input  wire logic [7:0] width,
	output logic            gate_src
);
	logic [7:0] left_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			left_q <= 8'h00;
		end else if (fire) begin
			left_q <= width;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	assign gate_src = (left_q != 8'h00);
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the gated timer
// assumes gtimer_pkg, gate_pulse_src and gated_timer are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	// ==========================================================
	// stimulus and design
	logic clk = 1'b0, rst = 1'b1, tick = 1'b0, ext_run = 1'b0, sleep = 1'b0;
	logic go_set = 1'b0, go_clr = 1'b0, hi_we = 1'b0, lo_we = 1'b0, ovf_clr = 1'b0;
	logic gev_clr = 1'b0, osc_en = 1'b0, fire = 1'b0;
	logic [7:0] wdata = 8'h00, width = 8'h00;
	gtimer_pkg::timer_cfg_type  cfg = '0;
	gtimer_pkg::irq_cfg_type    irq = '0;
	gtimer_pkg::capcomp_in_type cc = '0;
	wire logic gate_src;
	logic [15:0] count, cap_val, v;
	logic go_done, gstat, gev, girq, ovf, oirq, wake, cap_vld, cmp_ev, osc_run;
	int n_errors = 0;
	int checks = 0;

	gate_pulse_src gsrc (.clk(clk), .rst(rst), .fire(fire), .width(width), .gate_src(gate_src));
	gated_timer uut (
		.clk(clk), .rst(rst), .tick(tick), .ext_clock_running(ext_run), .sleep_mode(sleep),
		.gate_src(gate_src), .cfg(cfg), .irq_cfg(irq), .cc_in(cc), .pulse_go_set(go_set),
		.pulse_go_clr(go_clr), .count_high_we(hi_we), .count_low_we(lo_we),
		.count_wdata(wdata), .overflow_flag_clr(ovf_clr), .gate_event_flag_clr(gev_clr),
		.secondary_osc_enable(osc_en), .count(count), .pulse_go_done(go_done),
		.gate_level_status(gstat), .gate_event_flag(gev), .gate_irq(girq),
		.overflow_flag(ovf), .overflow_irq(oirq), .wake(wake), .capture_value(cap_val),
		.capture_valid(cap_vld), .compare_event(cmp_ev), .secondary_osc_run(osc_run)
	);

	always #10 clk = ~clk;

	// ==========================================================
	// tasks
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// an interrupt or wake line is the and of its enables, given a set flag
	function automatic logic exp_irq(input logic on, input logic ovf_en, input logic per_en,
		input logic last_en);
		return on & ovf_en & per_en & last_en;
	endfunction
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] val);
		@(posedge clk);
		hi_we <= 1'b1;
		wdata <= val[15:8];
		@(posedge clk);
		hi_we <= 1'b0;
		lo_we <= 1'b1;
		wdata <= val[7:0];
		@(posedge clk);
		lo_we <= 1'b0;
	endtask
	task automatic gate_pulse(input logic [7:0] w);
		@(posedge clk);
		fire <= 1'b1;
		width <= w;
		@(posedge clk);
		fire <= 1'b0;
		repeat (w + 3) begin
			settle();
			if (!cfg.toggle_mode_enable) `CHK("gate_status", gate_src, gstat)
		end
	endtask

	// ==========================================================
	// watchdog
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// ==========================================================
	// scenarios
	initial begin
		void'($urandom(32'hBC14));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		cfg.gate_polarity <= 1'b1;
		osc_en <= 1'b1;
		gate_pulse(8'h03);
		`CHK("gev_flag", 1'b1, gev);
		`CHK("gev_irq_off", 1'b0, girq);
		@(posedge clk);
		irq.gate_event_irq_enable <= 1'b1;
		settle();
		`CHK("gev_irq_on", 1'b1, girq);
		`CHK("osc_run", 1'b1, osc_run);
		// single pulse: enable first, then go
		@(posedge clk);
		cfg <= 6'h2D;
		tick <= 1'b1;
		@(posedge clk);
		go_set <= 1'b1;
		@(posedge clk);
		go_set <= 1'b0;
		repeat (3) settle();
		`CHK("armed_hold", 16'h0000, count);
		gate_pulse(8'h04);
		`CHK("go_done_clr", 1'b0, go_done);
		v = count;
		`CHK("pulse_counted", 1'b1, v != 16'h0000);
		gate_pulse(8'h04);
		`CHK("no_recount", v, count);
		@(posedge clk);
		cfg.toggle_mode_enable <= 1'b1;
		go_set <= 1'b1;
		@(posedge clk);
		go_set <= 1'b0;
		gate_pulse(8'h03);
		`CHK("tgl_half", 1'b1, go_done);
		gate_pulse(8'h03);
		`CHK("tgl_full", 1'b0, go_done);
		@(posedge clk);
		go_set <= 1'b1;
		@(posedge clk);
		go_set <= 1'b0;
		settle();
		`CHK("go_rearm", 1'b1, go_done);
		@(posedge clk);
		cfg <= 6'h2C;
		go_clr <= 1'b1;
		tick <= 1'b0;
		@(posedge clk);
		go_clr <= 1'b0;
		tick <= 1'b1;
		settle();
		`CHK("go_clr", 1'b0, go_done);
		// plain gate: count only while the level matches the polarity
		v = count;
		gate_pulse(8'h05);
		`CHK("gated_count", 16'(v + 16'h0005), count);
		@(posedge clk);
		cfg.gate_polarity <= 1'b0;
		settle();
		v = count;
		repeat (4) settle();
		`CHK("inv_gate_count", 16'(v + 16'h0004), count);
		@(posedge clk);
		cfg <= 6'h24;
		tick <= 1'b0;
		// wrap and overflow interrupt gating
		wr(16'hFFFF);
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		#1;
		`CHK("wrap", 16'h0000, count);
		`CHK("ovf_set", 1'b1, ovf);
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			{cfg.on, irq.overflow_irq_enable, irq.peripheral_irq_enable} <= i[4:2];
			{irq.global_irq_enable, cfg.sync_disable} <= i[1:0];
			sleep <= 1'b1;
			ext_run <= 1'b1;
			settle();
			`CHK("ovf_irq", exp_irq(i[4], i[3], i[2], i[1]), oirq);
			`CHK("wake", exp_irq(i[4], i[3], i[2], i[0]), wake);
		end
		`CHK("ovf_held", 1'b1, ovf);
		@(posedge clk);
		ovf_clr <= 1'b1;
		@(posedge clk);
		ovf_clr <= 1'b0;
		#1;
		`CHK("ovf_clr", 1'b0, ovf);
		`CHK("ovf_irq_off", 1'b0, oirq);
		// counting in sleep needs the asynchronous setting
		for (int i = 0; i < 4; i++) begin
			v = 16'($urandom_range(16'hFEFF));
			wr(v);
			@(posedge clk);
			cfg.sync_disable <= i[0];
			ext_run <= i[1];
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			#1;
			`CHK("sleep_count", 16'(v + (i[0] & i[1])), count);
		end
		// compare match with auto clear, then write priority
		@(posedge clk);
		sleep <= 1'b0;
		cfg.sync_disable <= 1'b0;
		cc <= {4'h6, 16'(v + 16'h0003)};
		tick <= 1'b1;
		repeat (10) begin
			settle();
			if (cmp_ev === 1'b1) break;
		end
		`CHK("cmp_match", cc.capcomp, count);
		@(posedge clk);
		tick <= 1'b0;
		cc.capcomp <= 16'h0000;
		#1;
		`CHK("auto_clr", 16'h0000, count);
		`CHK("auto_no_ovf", 1'b0, ovf);
		@(posedge clk);
		lo_we <= 1'b1;
		wdata <= 8'h55;
		@(posedge clk);
		lo_we <= 1'b0;
		#1;
		`CHK("wr_wins", 16'h0055, count);
		@(posedge clk);
		cc <= {4'h9, 16'h0000};
		@(posedge clk);
		cc.capture_event <= 1'b0;
		#1;
		`CHK("cap_val", 16'h0055, cap_val);
		`CHK("cap_vld", 1'b1, cap_vld);
		finish_test();
	end
endmodule
`default_nettype wire

// File: hw/gate_edge_unit.sv
// gate path: toggle flip-flop, gate level and edge detection
// assumes gate_src is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module gate_edge_unit (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic gate_src,
	input  wire logic gate_polarity,
	input  wire logic toggle_mode_enable,
	output logic      gate_level,
	output logic      gate_rise,
	output logic      gate_fall
);
	// ==========================================================
	// toggle flip-flop and level
	logic src_q;
	logic tog_q;
	logic lvl_q;
	logic pol_src;

	assign pol_src = gate_src ~^ gate_polarity;

	always_ff @(posedge clk) begin
		if (rst) begin
			src_q <= 1'b0;
		end else begin
			src_q <= pol_src;
		end
	end

	// flip-flop held clear while toggle mode is off
	always_ff @(posedge clk) begin
		if (rst || !toggle_mode_enable) begin
			tog_q <= 1'b0;
		end else if (pol_src && !src_q) begin
			tog_q <= ~tog_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= toggle_mode_enable ? tog_q : pol_src;
		end
	end

	assign gate_level = toggle_mode_enable ? tog_q : pol_src;
	assign gate_rise  = gate_level && !lvl_q;
	assign gate_fall  = !gate_level && lvl_q;

	a_fall_edge: assert property (@(posedge clk) disable iff (rst)
		gate_fall |-> $past(gate_level) && !gate_level)
		else $error("fall pulse without level drop");
endmodule
`default_nettype wire

// File: hw/gated_timer.sv
// gated 16-bit timer with single-pulse gate, gate events and capture/compare base
// assumes all inputs synchronous to clk; tick is a one-cycle timer clock enable
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - after go/done, counting enables on next rising gate edge
// - go/done cleared by hardware on gate level falling edge
// - after done, gate events no longer increment until go/done set again
// - toggle and single-pulse together measure one full gate cycle
// - gate level status always shows gate level, even ungated
// - gate level falling edge sets gate event flag; irq needs enable
// - gate event flag sets even with gate enable cleared
// - counter counts to FFFF, wraps to 0000, sets overflow flag
// - overflow irq needs on, overflow, peripheral and global enables
// - in sleep, counts only asynchronously on a running external clock
// - overflow in sleep wakes device; vectors only with global enable
// - secondary oscillator keeps running in sleep
// - capture copies full counter into capture/compare pair on event
// - compare raises event when pair equals counter
// - auto-conversion clears counter without setting overflow flag
// - with auto-conversion the pair acts as period register
// - counter write in same cycle as auto clear wins
// - gated counting only while gate level matches polarity
module gated_timer (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       tick,
	input  wire logic                       ext_clock_running,
	input  wire logic                       sleep_mode,
	input  wire logic                       gate_src,
	input  wire gtimer_pkg::timer_cfg_type  cfg,
	input  wire gtimer_pkg::irq_cfg_type    irq_cfg,
	input  wire gtimer_pkg::capcomp_in_type cc_in,
	input  wire logic                       pulse_go_set,
	input  wire logic                       pulse_go_clr,
	input  wire logic                       count_high_we,
	input  wire logic                       count_low_we,
	input  wire logic [7:0]                 count_wdata,
	input  wire logic                       overflow_flag_clr,
	input  wire logic                       gate_event_flag_clr,
	input  wire logic                       secondary_osc_enable,
	output logic [15:0]                     count,
	output logic                            pulse_go_done,
	output logic                            gate_level_status,
	output logic                            gate_event_flag,
	output logic                            gate_irq,
	output logic                            overflow_flag,
	output logic                            overflow_irq,
	output logic                            wake,
	output logic [15:0]                     capture_value,
	output logic                            capture_valid,
	output logic                            compare_event,
	output logic                            secondary_osc_run
);
	// ==========================================================
	// gate path
	logic gate_level;
	logic gate_rise;
	logic gate_fall;

	gate_edge_unit u_gate (
		.clk                (clk),
		.rst                (rst),
		.gate_src           (gate_src),
		.gate_polarity      (cfg.gate_polarity),
		.toggle_mode_enable (cfg.toggle_mode_enable),
		.gate_level         (gate_level),
		.gate_rise          (gate_rise),
		.gate_fall          (gate_fall)
	);

	assign gate_level_status = gate_level;

	// ==========================================================
	// single-pulse control
	logic go_q;
	logic armed_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			go_q <= 1'b0;
		end else if (pulse_go_set) begin
			go_q <= 1'b1;
		end else if (pulse_go_clr || (cfg.single_pulse_enable && gate_fall && go_q)) begin
			go_q <= 1'b0;
		end
	end

	// armed from the rising gate edge after go until done
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (!go_q || gate_fall) begin
			armed_q <= 1'b0;
		end else if (gate_rise) begin
			armed_q <= 1'b1;
		end
	end

	assign pulse_go_done = go_q;

	// ==========================================================
	// count enable
	logic gate_ok;
	logic sleep_ok;
	logic count_en;
	logic auto_clr;
	logic period_hit;

	always_comb begin
		if (!cfg.gate_enable) begin
			gate_ok = 1'b1;
		end else if (cfg.single_pulse_enable) begin
			gate_ok = armed_q && gate_level;
		end else begin
			gate_ok = gate_level;
		end
	end

	assign sleep_ok = !sleep_mode || (cfg.sync_disable && ext_clock_running);
	assign count_en = cfg.on && tick && gate_ok && sleep_ok;

	// ==========================================================
	// counter
	logic [15:0] count_q;
	logic        wrap;

	assign period_hit    = cc_in.compare_mode && (cc_in.capcomp == count_q);
	assign compare_event = period_hit;
	assign auto_clr      = period_hit && cc_in.auto_conv;
	assign wrap          = count_en && (count_q == gtimer_pkg::COUNT_MAX) && !auto_clr;

	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= gtimer_pkg::COUNT_RST;
		end else if (count_high_we || count_low_we) begin
			if (count_high_we) begin
				count_q[15:8] <= count_wdata;
			end
			if (count_low_we) begin
				count_q[7:0] <= count_wdata;
			end
		end else if (auto_clr) begin
			count_q <= gtimer_pkg::COUNT_ZERO;
		end else if (count_en) begin
			count_q <= count_q + 16'h0001;
		end
	end

	assign count = count_q;

	// ==========================================================
	// flags, set wins over clear
	logic ovf_q;
	logic gev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else if (wrap && !(count_high_we || count_low_we)) begin
			ovf_q <= 1'b1;
		end else if (overflow_flag_clr) begin
			ovf_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gev_q <= 1'b0;
		end else if (gate_fall) begin
			gev_q <= 1'b1;
		end else if (gate_event_flag_clr) begin
			gev_q <= 1'b0;
		end
	end

	assign overflow_flag   = ovf_q;
	assign gate_event_flag = gev_q;
	assign gate_irq        = gev_q && irq_cfg.gate_event_irq_enable;
	assign overflow_irq    = ovf_q && cfg.on && irq_cfg.overflow_irq_enable
		&& irq_cfg.peripheral_irq_enable && irq_cfg.global_irq_enable;
	assign wake = sleep_mode && ovf_q && cfg.on && cfg.sync_disable
		&& irq_cfg.overflow_irq_enable && irq_cfg.peripheral_irq_enable;
	assign secondary_osc_run = secondary_osc_enable;

	// ==========================================================
	// capture
	logic [15:0] cap_q;
	logic        capv_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_q  <= gtimer_pkg::COUNT_RST;
			capv_q <= 1'b0;
		end else begin
			capv_q <= cc_in.capture_mode && cc_in.capture_event;
			if (cc_in.capture_mode && cc_in.capture_event) begin
				cap_q <= count_q;
			end
		end
	end

	assign capture_value = cap_q;
	assign capture_valid = capv_q;

	// ==========================================================
	// checks
	a_wrap_sets_ovf: assert property (@(posedge clk) disable iff (rst)
		wrap && !count_high_we && !count_low_we |=> ovf_q && count_q == 16'h0000)
		else $error("wrap did not set overflow");
	a_ovf_sticky: assert property (@(posedge clk) disable iff (rst)
		ovf_q && !overflow_flag_clr |=> ovf_q)
		else $error("overflow flag dropped");
	a_auto_no_ovf: assert property (@(posedge clk) disable iff (rst)
		auto_clr && !count_high_we && !count_low_we && !ovf_q |=> count_q == 16'h0000 && !ovf_q)
		else $error("auto clear wrong");
	a_write_wins: assert property (@(posedge clk) disable iff (rst)
		auto_clr && count_high_we && count_low_we |=> count_q == {2{$past(count_wdata)}})
		else $error("write lost to auto clear");
	a_done_clears: assert property (@(posedge clk) disable iff (rst)
		cfg.single_pulse_enable && go_q && gate_fall && !pulse_go_set |=> !go_q)
		else $error("go/done not cleared");
	a_no_count_done: assert property (@(posedge clk) disable iff (rst)
		cfg.gate_enable && cfg.single_pulse_enable && !go_q && !armed_q && !auto_clr
		&& !count_high_we && !count_low_we |=> count_q == $past(count_q))
		else $error("count after done");
	a_gate_event: assert property (@(posedge clk) disable iff (rst)
		gate_fall |=> gev_q)
		else $error("gate event flag not set");
	a_gate_hold: assert property (@(posedge clk) disable iff (rst)
		cfg.gate_enable && !cfg.single_pulse_enable && !gate_level && !auto_clr
		&& !count_high_we && !count_low_we |=> count_q == $past(count_q))
		else $error("count while gate closed");
	a_capture_copy: assert property (@(posedge clk) disable iff (rst)
		cc_in.capture_mode && cc_in.capture_event |=> cap_q == $past(count_q))
		else $error("capture value wrong");
	a_sleep_hold: assert property (@(posedge clk) disable iff (rst)
		sleep_mode && !cfg.sync_disable && !auto_clr
		&& !count_high_we && !count_low_we |=> count_q == $past(count_q))
		else $error("counted in sleep");

	c_pulse_done: cover property (@(posedge clk) disable iff (rst) go_q ##1 !go_q);
	c_wrap:       cover property (@(posedge clk) disable iff (rst) wrap);
	c_auto:       cover property (@(posedge clk) disable iff (rst) auto_clr);
	c_wake:       cover property (@(posedge clk) disable iff (rst) wake);
endmodule
`default_nettype wire

// File: hw/gtimer_pkg.sv
// package for the gated timer: widths, reset values and carrier structs
// assumes nothing of its surroundings
`default_nettype none
package gtimer_pkg;

	// ==========================================================
	// counter constants
	localparam int           COUNT_W    = 16;
	localparam logic [15:0]  COUNT_MAX  = 16'hFFFF;
	localparam logic [15:0]  COUNT_ZERO = 16'h0000;
	localparam logic [15:0]  COUNT_RST  = 16'h0000;

	// ==========================================================
	// carrier structs
	typedef struct packed {
		logic on;
		logic sync_disable;
		logic gate_enable;
		logic gate_polarity;
		logic toggle_mode_enable;
		logic single_pulse_enable;
	} timer_cfg_type;

	typedef struct packed {
		logic overflow_irq_enable;
		logic gate_event_irq_enable;
		logic peripheral_irq_enable;
		logic global_irq_enable;
	} irq_cfg_type;

	typedef struct packed {
		logic       capture_mode;
		logic       compare_mode;
		logic       auto_conv;
		logic       capture_event;
		logic [15:0] capcomp;
	} capcomp_in_type;

endpackage
`default_nettype wire
